// ---- verilog/wdog_top.sv ----
// Functional notes
// R1 - counter reaching timeout without service raises the watchdog reset request
// R2 - counter clock picked from autonomous, internal rc or oscillator clock
// R3 - autonomous clock stopped in stop: two cycles sync on entry and exit
// R4 - that latency applies for both full and pseudo stop
// R5 - software should not re-request stop within two autonomous cycles of exit
// R6 - autonomous select: run in stop if disable bit 0, static if 1
// R7 - otherwise run in stop only with pseudo, pseudo-run, osc sel, osc en, osc up
// R8 - all other non-autonomous setups hold the counter static in stop
// R9 - full stop disables external oscillator and clock monitor
// R10 - outside stop the counter advances each selected clock tick
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "wdog_regs.svh"

module wdog_top (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // clock sources, foreign domains
  input  wire logic        autonomous_clock,
  input  wire logic        internal_rc_clock,
  input  wire logic        oscillator_clock,
  input  wire logic        oscillator_up_flag,
  // power mode
  input  wire logic        stop_req,
  output logic             in_stop,
  // outputs to the system
  output logic             wdog_reset_req,
  output logic             oscillator_run,
  output logic             clock_monitor_en,
  output logic             irq
);

  // stop-mode counting condition for the non-autonomous sources
  function automatic logic stop_run_f(input logic [`WD_CTRL_W-1:0] c, input logic up);
    stop_run_f = c[`WD_CTRL_PSTOP] & c[`WD_CTRL_PS_RUN] & c[`WD_CTRL_OSC_SEL] &
                 c[`WD_CTRL_OSC_EN] & up;
  endfunction

  logic [`WD_CTRL_W-1:0]  ctrl_r;
  logic [`WD_CNT_W-1:0]   tmo_r;
  logic [`WD_CNT_W-1:0]   count_r;
  logic [`WD_CNT_W-1:0]   count_nxt;
  logic [`WD_INT_W-1:0]   ist_r;
  logic [`WD_INT_W-1:0]   imask_r;
  logic [`WD_INT_W-1:0]   ist_nxt;
  logic [1:0]             sync_r;
  logic [1:0]             sync_nxt;
  logic                   rst_req_r;
  logic                   osc_run_r;
  logic                   mon_en_r;
  logic [31:0]            prdata_r;
  wdog_pkg::stop_state_t  state_r;
  wdog_pkg::stop_state_t  state_nxt;

  wire aclk_tick;
  wire irc_tick;
  wire osc_tick;
  wire osc_up;

  // one synchroniser per foreign source
  clk_tick_sync u_aclk (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (autonomous_clock),
    .lvl     (),
    .rise    (aclk_tick)
  );

  clk_tick_sync u_irc (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (internal_rc_clock),
    .lvl     (),
    .rise    (irc_tick)
  );

  clk_tick_sync u_osc (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (oscillator_clock),
    .lvl     (),
    .rise    (osc_tick)
  );

  clk_tick_sync u_up (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (oscillator_up_flag),
    .lvl     (osc_up),
    .rise    ()
  );

  // configuration decode
  wire en       = ctrl_r[`WD_CTRL_EN];
  wire aut_sel  = ctrl_r[`WD_CTRL_AUT_SEL];
  wire aut_dis  = ctrl_r[`WD_CTRL_AUT_DIS];
  wire pstop    = ctrl_r[`WD_CTRL_PSTOP];
  wire lat_mode = aut_sel & aut_dis;
  wire full_nxt = (state_nxt == wdog_pkg::ST_STOP) & ~pstop;

  // source mux; the oscillator only ticks while it is enabled and running
  wire osc_ok   = osc_tick & osc_run_r & osc_up;
  wire sel_tick = aut_sel ? aclk_tick : (ctrl_r[`WD_CTRL_OSC_SEL] ? osc_ok : irc_tick); // R2
  wire stop_run = aut_sel ? ~aut_dis : stop_run_f(ctrl_r, osc_up); // R6 R7 R8

  // counter advance and timeout
  wire stopped  = (state_r == wdog_pkg::ST_STOP);
  wire adv      = en & ~rst_req_r & sel_tick & (~stopped | stop_run); // R10
  wire hit      = adv & (count_r == tmo_r); // R1

  // apb decode
  wire setup    = psel & ~penable;
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire rd       = acc & ~pwrite;
  wire a_ctrl   = (paddr == `WD_CTRL_OFS);
  wire a_svc    = (paddr == `WD_SERVICE_OFS);
  wire a_tmo    = (paddr == `WD_TIMEOUT_OFS);
  wire a_stat   = (paddr == `WD_STATUS_OFS);
  wire a_ist    = (paddr == `WD_INT_STAT_OFS);
  wire a_imsk   = (paddr == `WD_INT_MASK_OFS);
  wire mapped   = a_ctrl | a_svc | a_tmo | a_stat | a_ist | a_imsk;
  wire service  = wr & a_svc & (pwdata[7:0] == `WD_SVC_KEY);

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = prdata_r;

  // read mux, sampled in the setup cycle so prdata comes from a flop
  wire [31:0] status_w = {12'h000, (state_r == wdog_pkg::ST_ENTER) | (state_r == wdog_pkg::ST_EXIT),
                          rst_req_r, stopped, osc_up, count_r};
  wire [31:0] rd_mux =
    a_ctrl ? {25'h0000000, ctrl_r} :
    a_tmo  ? {16'h0000, tmo_r} :
    a_stat ? status_w :
    a_ist  ? {29'h00000000, ist_r} :
    a_imsk ? {29'h00000000, imask_r} : 32'h00000000;

  // stop sequencer; the sync steps exist only when aclk halts in stop
  always_comb begin
    state_nxt = state_r;
    sync_nxt  = sync_r;
    case (state_r)
      wdog_pkg::ST_RUN: begin
        sync_nxt = 2'h0;
        if (stop_req) begin
          state_nxt = lat_mode ? wdog_pkg::ST_ENTER : wdog_pkg::ST_STOP; // R3 R4
        end
      end
      wdog_pkg::ST_ENTER: begin
        if (aclk_tick) begin
          sync_nxt = sync_r + 2'h1;
          if (sync_r + 2'h1 == `WD_SYNC_ACLK) begin
            state_nxt = wdog_pkg::ST_STOP; // R3
            sync_nxt  = 2'h0;
          end
        end
      end
      wdog_pkg::ST_STOP: begin
        sync_nxt = 2'h0;
        if (!stop_req) begin
          state_nxt = lat_mode ? wdog_pkg::ST_EXIT : wdog_pkg::ST_RUN; // R3 R4
        end
      end
      wdog_pkg::ST_EXIT: begin
        // a new stop request waits here until the exit sync ends
        if (aclk_tick) begin
          sync_nxt = sync_r + 2'h1;
          if (sync_r + 2'h1 == `WD_SYNC_ACLK) begin
            state_nxt = wdog_pkg::ST_RUN; // R3 R5
            sync_nxt  = 2'h0;
          end
        end
      end
      default: begin
        state_nxt = wdog_pkg::ST_RUN;
        sync_nxt  = 2'h0;
      end
    endcase
  end

  // events; a set beats the read clear in the same cycle
  wire ev_in  = (state_nxt == wdog_pkg::ST_STOP) & ~stopped;
  wire ev_out = (state_nxt == wdog_pkg::ST_RUN) & (state_r != wdog_pkg::ST_RUN);
  wire [`WD_INT_W-1:0] ev_set = {ev_out, ev_in, hit};
  wire [`WD_INT_W-1:0] ev_clr = (rd & a_ist) ? prdata_r[`WD_INT_W-1:0] : 3'h0;
  assign ist_nxt   = (ist_r & ~ev_clr) | ev_set;

  // counter next value; service restarts it and drops the reset request
  assign count_nxt = service ? 16'h0000 : (adv & ~hit) ? count_r + 16'h0001 : count_r;

  // state and counter flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= wdog_pkg::ST_RUN;
      sync_r  <= 2'h0;
      count_r <= 16'h0000;
      ist_r   <= 3'h0;
    end else begin
      state_r <= state_nxt;
      sync_r  <= sync_nxt;
      count_r <= count_nxt;
      ist_r   <= ist_nxt;
    end
  end

  // reset request holds until serviced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_req_r <= 1'b0;
    end else if (hit) begin
      rst_req_r <= 1'b1; // R1
    end else if (service) begin
      rst_req_r <= 1'b0;
    end
  end

  // oscillator and clock monitor are off through full stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run_r <= 1'b0;
      mon_en_r  <= 1'b0;
    end else begin
      osc_run_r <= ctrl_r[`WD_CTRL_OSC_EN] & ~full_nxt; // R9
      mon_en_r  <= ~full_nxt; // R9
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= `WD_CTRL_RST;
      tmo_r    <= `WD_TIMEOUT_RST;
      imask_r  <= `WD_MASK_RST;
      prdata_r <= 32'h00000000;
    end else begin
      if (wr & a_ctrl) begin
        ctrl_r <= pwdata[`WD_CTRL_W-1:0];
      end
      if (wr & a_tmo) begin
        tmo_r <= pwdata[`WD_CNT_W-1:0];
      end
      if (wr & a_imsk) begin
        imask_r <= pwdata[`WD_INT_W-1:0];
      end
      if (setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  assign wdog_reset_req   = rst_req_r;
  assign oscillator_run   = osc_run_r;
  assign clock_monitor_en = mon_en_r;
  assign in_stop          = stopped;
  assign irq              = |(ist_r & imask_r);

  // checks
  AST_TIMEOUT_RESET: assert property (@(posedge pclk) disable iff (!presetn) // R1
    hit |=> wdog_reset_req && ist_r[`WD_INT_TIMEOUT])
    else $error("timeout did not raise reset request");

  AST_SRC_AUT: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (en && aut_sel && !rst_req_r && !stopped && !service && aclk_tick && count_r != tmo_r)
      |=> count_r == $past(count_r) + 16'h0001)
    else $error("autonomous tick did not advance counter");

  AST_ENTRY_LAT: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (state_r == wdog_pkg::ST_RUN && stop_req && lat_mode) |=> !in_stop [*2])
    else $error("stop entered without sync latency");

  AST_EXIT_LAT: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (state_r == wdog_pkg::ST_EXIT && !(aclk_tick && sync_r == 2'h1))
      |=> state_r != wdog_pkg::ST_RUN)
    else $error("stop exit left sync early");

  AST_LAT_BOTH_MODES: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (state_r == wdog_pkg::ST_RUN && stop_req && lat_mode) |=> state_r == wdog_pkg::ST_ENTER)
    else $error("latency skipped for a stop flavour");

  AST_AUT_STATIC: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (stopped && lat_mode && !service) |=> $stable(count_r))
    else $error("counter moved in stop with autonomous clock disabled");

  AST_OSC_STOP_RUN: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (stopped && en && !aut_sel && stop_run_f(ctrl_r, osc_up) && osc_ok && !rst_req_r
     && !service && count_r != tmo_r) |=> count_r == $past(count_r) + 16'h0001)
    else $error("oscillator counter static in pseudo stop");

  AST_NONAUT_STATIC: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (stopped && !aut_sel && !stop_run_f(ctrl_r, osc_up) && !service) |=> $stable(count_r))
    else $error("counter moved in static stop configuration");

  AST_FULL_STOP_OFF: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (in_stop && !pstop && $stable(in_stop)) |-> !oscillator_run && !clock_monitor_en)
    else $error("oscillator or monitor alive in full stop");

  AST_RUN_ADVANCE: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (!stopped && en && sel_tick && !rst_req_r && !service && count_r != tmo_r)
      |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter missed a tick in run");

  // request and count both freeze until software services the watchdog
  AST_REQ_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (rst_req_r && !service) |=> wdog_reset_req)
    else $error("reset request dropped without service");

  AST_CNT_FROZEN: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (rst_req_r && !service) |=> $stable(count_r))
    else $error("counter moved while reset request pending");

  AST_SYNC_START: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (state_r == wdog_pkg::ST_ENTER && $past(state_r) == wdog_pkg::ST_RUN) |-> sync_r == 2'h0)
    else $error("entry sync started part way");

  AST_MON_BACK: assert property (@(posedge pclk) disable iff (!presetn) // R9
    !full_nxt |=> clock_monitor_en)
    else $error("clock monitor off outside full stop");

  AST_OSC_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn) // R9
    !full_nxt |=> oscillator_run == $past(ctrl_r[`WD_CTRL_OSC_EN]))
    else $error("oscillator run does not follow its enable");

  COV_TIMEOUT: cover property (@(posedge pclk) disable iff (!presetn) hit);
  COV_LAT_CYCLE: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == wdog_pkg::ST_EXIT ##1 state_r == wdog_pkg::ST_RUN);
  COV_OSC_STOP: cover property (@(posedge pclk) disable iff (!presetn)
    stopped && stop_run && adv);
  COV_LAT_ENTRY: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == wdog_pkg::ST_ENTER ##1 state_r == wdog_pkg::ST_STOP);
  COV_SERVICE_CLR: cover property (@(posedge pclk) disable iff (!presetn)
    rst_req_r && service);

endmodule

// ---- verilog/wdog_regs.svh ----
`ifndef WDOG_REGS_SVH
`define WDOG_REGS_SVH

// register byte offsets
`define WD_CTRL_OFS      8'h00
`define WD_SERVICE_OFS   8'h04
`define WD_TIMEOUT_OFS   8'h08
`define WD_STATUS_OFS    8'h0C
`define WD_INT_STAT_OFS  8'h10
`define WD_INT_MASK_OFS  8'h14

// control field positions
`define WD_CTRL_EN       0
`define WD_CTRL_OSC_SEL  1
`define WD_CTRL_AUT_SEL  2
`define WD_CTRL_AUT_DIS  3
`define WD_CTRL_PSTOP    4
`define WD_CTRL_PS_RUN   5
`define WD_CTRL_OSC_EN   6
`define WD_CTRL_W        7

// status field positions
`define WD_ST_OSC_UP     16
`define WD_ST_IN_STOP    17
`define WD_ST_RST_REQ    18
`define WD_ST_SYNCING    19

// interrupt bits
`define WD_INT_TIMEOUT   0
`define WD_INT_STOP_IN   1
`define WD_INT_STOP_OUT  2
`define WD_INT_W         3

// reset values and constants
`define WD_CTRL_RST      7'h00
`define WD_TIMEOUT_RST   16'h0FFF
`define WD_MASK_RST      3'h0
`define WD_SVC_KEY       8'hA5
`define WD_SYNC_ACLK     2'h2
`define WD_CNT_W         16

`endif

// ---- verilog/wdog_pkg.sv ----
package wdog_pkg;

  // stop sequencing, gray coded along run-enter-stop-exit
  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_ENTER = 2'h1,
    ST_STOP  = 2'h3,
    ST_EXIT  = 2'h2
  } stop_state_t;

endpackage

// ---- verilog/clk_tick_sync.sv ----
`timescale 1ns/1ps

module clk_tick_sync (
  // system
  input  wire logic pclk,
  input  wire logic presetn,
  // foreign level
  input  wire logic din,
  // synchronised outputs
  output logic      lvl,
  output logic      rise
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // two flops, then an edge register; meta_r feeds sync_r only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // source clock must stay below pclk/2 or edges are lost
  assign lvl  = sync_r;
  assign rise = sync_r & ~last_r;

endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [7:0] a; logic [31:0] exp; logic er;} row_t;
  typedef struct {logic [6:0] c; logic up; logic run; logic lat;} stp_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic        aclk = 1'b0;
  logic        rclk = 1'b0;
  logic        oclk = 1'b0;
  logic        stop_req = 1'b0;
  logic        up = 1'b1;
  logic        in_stop, rst_req, osc_run, mon_en, irq;
  logic [15:0] c1;
  int          err_total = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;
  // register reset values, last row unmapped
  row_t rows[6] = '{'{8'h00, 32'h0, 1'b0}, '{8'h08, 32'h00000FFF, 1'b0}, '{8'h0C, 32'h00010000, 1'b0},
                    '{8'h10, 32'h0, 1'b0}, '{8'h14, 32'h0, 1'b0}, '{8'h18, 32'h0, 1'b1}};
  // counter sources: rc, oscillator, autonomous
  logic [6:0] srcs[3] = '{7'h01, 7'h43, 7'h05};
  // stop setups: control value, oscillator up, counter runs, sync latency
  stp_t st[8] = '{'{7'h05, 1'b1, 1'b1, 1'b0}, '{7'h0D, 1'b1, 1'b0, 1'b1}, '{7'h1D, 1'b1, 1'b0, 1'b1},
                  '{7'h73, 1'b1, 1'b1, 1'b0}, '{7'h53, 1'b1, 1'b0, 1'b0}, '{7'h01, 1'b1, 1'b0, 1'b0},
                  '{7'h43, 1'b1, 1'b0, 1'b0}, '{7'h73, 1'b0, 1'b0, 1'b0}};

  wdog_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .autonomous_clock(aclk), .internal_rc_clock(rclk), .oscillator_clock(oclk),
    .oscillator_up_flag(up), .stop_req(stop_req), .in_stop(in_stop),
    .wdog_reset_req(rst_req), .oscillator_run(osc_run), .clock_monitor_en(mon_en), .irq(irq)
  );

  always #25 pclk = ~pclk;

  // slow source pins, phases kept well above two pclk so the syncs see them
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 0) aclk <= ~aclk;
    if (cyc % 3 == 0) rclk <= ~rclk;
    if (cyc % 5 == 0) oclk <= ~oclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_stop(input logic want);
    n = 0;
    while (in_stop !== want && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(in_stop, want);
  endtask

  // hang guard, far beyond the expected run
  initial begin
    #2000000;
    err_total++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].exp);
      chk(err, rows[i].er);
      chk(pready, 1'b1);
    end
    // short timeout on each source, then a bad and a good service key
    foreach (srcs[i]) begin
      apb(1'b1, 8'h08, 32'h3);
      apb(1'b1, 8'h04, 32'hA5);
      apb(1'b1, 8'h00, {25'h0, srcs[i]});
      n = 0;
      while (rst_req !== 1'b1 && n < 300) begin
        @(posedge pclk);
        n++;
      end
      chk(rst_req, 1'b1);
      apb(1'b0, 8'h0C, 32'h0);
      chk({rd[18], rd[15:0]}, {1'b1, 16'h0003});
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h04, 32'h5A);
      chk(rst_req, 1'b1);
      apb(1'b1, 8'h04, 32'hA5);
      @(posedge pclk);
      chk(rst_req, 1'b0);
    end
    // timeout event: unmask, mask, read clears
    apb(1'b1, 8'h14, 32'h1);
    @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, 8'h14, 32'h0);
    @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h1);
    @(posedge pclk);
    chk(irq, 1'b0);
    // stop behaviour for each setup; counter sampled twice while stopped
    foreach (st[i]) begin
      apb(1'b1, 8'h08, 32'hFFFF);
      apb(1'b1, 8'h04, 32'hA5);
      apb(1'b1, 8'h00, {25'h0, st[i].c});
      up <= st[i].up;
      repeat (20) @(posedge pclk);
      stop_req <= 1'b1;
      if (st[i].lat) begin
        repeat (4) @(posedge pclk);
        chk(in_stop, 1'b0);
      end
      wait_stop(1'b1);
      if (!st[i].c[4]) chk({osc_run, mon_en}, 2'b00);
      apb(1'b0, 8'h0C, 32'h0);
      c1 = rd[15:0];
      repeat (40) @(posedge pclk);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd[15:0] !== c1, st[i].run);
      stop_req <= 1'b0;
      wait_stop(1'b0);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd[19], st[i].lat);
      repeat (20) @(posedge pclk);
      chk(mon_en, 1'b1);
      chk(osc_run, st[i].c[6]);
    end
    // stop entered and exited events stay sticky until read
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h6);
    // reset again in mid-run
    apb(1'b1, 8'h00, 32'h41);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({in_stop, rst_req, irq, mon_en, osc_run}, 5'h00);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({mon_en, osc_run}, 2'b10);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    end_sim();
  end
endmodule
